// ==== logic/tm8_pkg.sv ====
// Purpose: constants and state type of the 8-bit timer
// Assumes: byte-wide special function register port
// Notes: offsets are the register port addresses
package tm8_pkg;
    localparam logic [7:0] ADDR_CNT = 8'hCA;
    localparam logic [7:0] ADDR_CTL = 8'hCB;
    localparam logic [7:0] ADDR_CCTL0 = 8'hCC;
    localparam logic [7:0] ADDR_CC0 = 8'hCD;
    localparam logic [7:0] ADDR_CC1 = 8'hCF;
    localparam int CTL_DIV_HI = 7;
    localparam int CTL_DIV_LO = 5;
    localparam int CTL_START = 4;
    localparam int CTL_OVERFLOW_IRQ_MASK = 3;
    localparam int CTL_CLR = 2;
    localparam int CCTL_IM = 6;
    localparam int CCTL_CMP_HI = 5;
    localparam int CCTL_CMP_LO = 3;
    localparam int CCTL_MODE = 2;
    localparam logic [7:0] CTL_RST = 8'h08;
    localparam logic [7:0] CCTL_RST = 8'h40;
    localparam logic [7:0] CTL_WMASK = 8'hFB;
    localparam logic [7:0] CCTL_WMASK = 8'h7F;
    localparam logic [7:0] CNT_TOP = 8'hFF;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    typedef enum logic [1:0] {
        MODE_FREE = 2'b00,
        MODE_DOWN = 2'b01,
        MODE_MOD = 2'b10,
        MODE_UPDN = 2'b11
    } tm8_mode_t;
    typedef enum logic [2:0] {
        ACT_SET = 3'b000,
        ACT_CLR = 3'b001,
        ACT_TOG = 3'b010,
        ACT_UPSET = 3'b011,
        ACT_UPCLR = 3'b100,
        ACT_SET_TOP = 3'b101,
        ACT_CLR_ZERO = 3'b110,
        ACT_NONE = 3'b111
    } tm8_act_t;
    typedef enum logic [1:0] {
        CAP_OFF = 2'b00,
        CAP_RISE = 2'b01,
        CAP_FALL = 2'b10,
        CAP_BOTH = 2'b11
    } tm8_cap_t;
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] cctl;
        logic [7:0] cnt;
        logic [7:0] cc0;
        logic [7:0] cc0_act;
        logic [7:0] cc1;
        logic [7:0] rdata;
        logic [6:0] presc;
        logic down;
        logic s1;
        logic s2;
        logic s3;
        logic out;
        logic ovf_p;
        logic ch0_p;
        logic dma0_p;
        logic dma1_p;
        logic ovf_irq;
        logic ch0_irq;
    } tm8_state_t;
    localparam tm8_state_t ST_RST = '{ctl: CTL_RST, cctl: CCTL_RST, default: '0};
endpackage : tm8_pkg

// ==== logic/tm8_timer.sv ====
// Purpose: 8-bit timer, one capture/compare channel
// Assumes: TICK is a one-cycle pulse on CLK
// Notes: flags leave as pulses to a shared flag register
`timescale 1ns/1ps
// Notes on behaviour
// - channel 0 compare pulses a DMA trigger
// - channel 1 compare pulses its own trigger
// - count register reads live count, resets zero
// - prescaler divides tick by two^field
// - start bit runs, start bit low halts counter
// - overflow mask resets one, gates request
// - clear bit zeroes counter, reads zero
// - free mode counts 0x00 to 0xFF, wraps
// - down mode loads compare, counts to zero
// - modulo mode counts up to compare value
// - up/down mode counts up then down
// - channel mode bit: capture or compare
// - capture edge: off, rise, fall, both
// - compare actions set, clear, toggle
// - actions 011/100 match-up versus zero, down match in up/down
// - actions 101/110 match versus top/zero
// - channel mask resets one, gates request
// - channel value register resets zero
// - capture copies count and sets flag
// - channel 0 compare updates at zero
// - terminal count sets overflow flag
module tm8_timer (
    input wire logic CLK,
    input wire logic RST,
    input wire logic TICK,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    input wire logic CH0_IN,
    output logic CH0_OUT,
    output logic CH0_OE_N,
    output logic OVF_FLAG,
    output logic OVF_IRQ,
    output logic CH0_FLAG,
    output logic CH0_IRQ,
    output logic DMA_CH0,
    output logic DMA_CH1
);
    import tm8_pkg::*;

    tm8_state_t s_reg;
    tm8_state_t s_next;
    tm8_mode_t mode;
    tm8_act_t act;
    tm8_cap_t cap;
    logic [6:0] mask;
    logic started, tick_hit, cmp_en, match0;
    logic up_m, dn_m, zero_ev, top_ev, rst_ev;
    logic wr_ctl, clr_w, load_w, rise, fall, cap_hit;

    assign mode = tm8_mode_t'(s_reg.ctl[1:0]);
    assign act = tm8_act_t'(s_reg.cctl[CCTL_CMP_HI:CCTL_CMP_LO]);
    assign cap = tm8_cap_t'(s_reg.cctl[1:0]);
    assign started = s_reg.ctl[CTL_START];
    assign mask = 7'((8'h01 << s_reg.ctl[CTL_DIV_HI:CTL_DIV_LO]) - 8'h01);
    assign tick_hit = TICK & started & ((s_reg.presc & mask) == mask);
    assign cmp_en = s_reg.cctl[CCTL_MODE];
    assign match0 = tick_hit & (s_reg.cnt == s_reg.cc0_act);
    assign up_m = match0 & ~(mode == MODE_UPDN && s_reg.down);
    assign dn_m = match0 & (mode == MODE_UPDN) & s_reg.down;
    assign zero_ev = tick_hit & (s_reg.cnt == CNT_ZERO);
    assign top_ev = tick_hit & (s_reg.cnt == CNT_TOP);
    // down match stands in for zero
    assign rst_ev = (mode == MODE_UPDN) ? dn_m : zero_ev;
    assign wr_ctl = SFR_WR & (SFR_ADDR == ADDR_CTL);
    assign clr_w = wr_ctl & SFR_WDATA[CTL_CLR];
    // down mode preloads on the start write
    assign load_w = wr_ctl & SFR_WDATA[CTL_START] & ~started &
                    (SFR_WDATA[1:0] == MODE_DOWN);
    // only the second and third stages are compared
    assign rise = s_reg.s2 & ~s_reg.s3;
    assign fall = ~s_reg.s2 & s_reg.s3;
    always_comb begin
        case (cap)
            CAP_RISE: cap_hit = rise;
            CAP_FALL: cap_hit = fall;
            CAP_BOTH: cap_hit = rise | fall;
            default: cap_hit = 1'b0;
        endcase
        cap_hit = cap_hit & started & ~cmp_en;
    end

    always_comb begin
        s_next = s_reg;
        s_next.s1 = CH0_IN;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        s_next.ovf_p = 1'b0;
        s_next.ch0_p = 1'b0;
        s_next.dma0_p = 1'b0;
        s_next.dma1_p = 1'b0;
        if (TICK && started) begin
            s_next.presc = s_reg.presc + 7'h01;
        end
        // counter moves only on active edges
        if (tick_hit) begin
            case (mode)
                MODE_FREE: begin
                    s_next.cnt = s_reg.cnt + 8'h01;
                    s_next.ovf_p = (s_reg.cnt == CNT_TOP);
                end
                MODE_DOWN: begin
                    if (s_reg.cnt != CNT_ZERO) begin
                        s_next.cnt = s_reg.cnt - 8'h01;
                        s_next.ovf_p = (s_reg.cnt == 8'h01);
                    end
                end
                MODE_MOD: begin
                    if (s_reg.cnt == s_reg.cc0_act) begin
                        s_next.cnt = CNT_ZERO;
                        s_next.ovf_p = 1'b1;
                    end else begin
                        s_next.cnt = s_reg.cnt + 8'h01;
                    end
                end
                // turn at compare and at zero
                default: begin
                    if (!s_reg.down) begin
                        if (s_reg.cnt == s_reg.cc0_act && s_reg.cnt != CNT_ZERO) begin
                            s_next.down = 1'b1;
                            s_next.cnt = s_reg.cnt - 8'h01;
                        end else if (s_reg.cnt != s_reg.cc0_act) begin
                            s_next.cnt = s_reg.cnt + 8'h01;
                        end
                    end else if (s_reg.cnt == CNT_ZERO) begin
                        s_next.down = 1'b0;
                        s_next.cnt = 8'h01;
                        s_next.ovf_p = 1'b1;
                    end else begin
                        s_next.cnt = s_reg.cnt - 8'h01;
                    end
                end
            endcase
        end
        if (s_reg.cnt == CNT_ZERO) begin
            s_next.cc0_act = s_reg.cc0;
        end
        if (cmp_en) begin
            case (act)
                ACT_SET: if (match0) s_next.out = 1'b1;
                ACT_CLR: if (match0) s_next.out = 1'b0;
                ACT_TOG: if (match0) s_next.out = ~s_reg.out;
                ACT_UPSET: begin
                    if (up_m) s_next.out = 1'b1;
                    else if (rst_ev) s_next.out = 1'b0;
                end
                ACT_UPCLR: begin
                    if (up_m) s_next.out = 1'b0;
                    else if (rst_ev) s_next.out = 1'b1;
                end
                ACT_SET_TOP: begin
                    if (match0) s_next.out = 1'b1;
                    else if (top_ev) s_next.out = 1'b0;
                end
                ACT_CLR_ZERO: begin
                    if (match0) s_next.out = 1'b0;
                    else if (zero_ev) s_next.out = 1'b1;
                end
                default: s_next.out = s_reg.out;
            endcase
            s_next.dma0_p = match0;
            s_next.ch0_p = match0;
        end
        // channel 1 trigger, value live at once
        s_next.dma1_p = tick_hit & (s_reg.cnt == s_reg.cc1);
        if (SFR_WR) begin
            if (SFR_ADDR == ADDR_CTL) begin
                s_next.ctl = SFR_WDATA & CTL_WMASK;
            end else if (SFR_ADDR == ADDR_CCTL0) begin
                s_next.cctl = SFR_WDATA & CCTL_WMASK;
            end else if (SFR_ADDR == ADDR_CC0) begin
                s_next.cc0 = SFR_WDATA;
            end else if (SFR_ADDR == ADDR_CC1) begin
                s_next.cc1 = SFR_WDATA;
            end
        end
        if (load_w) begin
            s_next.cnt = s_reg.cc0;
        end
        if (clr_w) begin
            s_next.cnt = CNT_ZERO;
            s_next.down = 1'b0;
            s_next.presc = 7'h00;
        end
        if (cap_hit) begin
            s_next.cc0 = s_reg.cnt;
            s_next.ch0_p = 1'b1;
        end
        s_next.ovf_irq = s_next.ovf_p & s_reg.ctl[CTL_OVERFLOW_IRQ_MASK];
        s_next.ch0_irq = s_next.ch0_p & s_reg.cctl[CCTL_IM];
        if (SFR_ADDR == ADDR_CNT) begin
            s_next.rdata = s_reg.cnt;
        end else if (SFR_ADDR == ADDR_CTL) begin
            s_next.rdata = s_reg.ctl;
        end else if (SFR_ADDR == ADDR_CCTL0) begin
            s_next.rdata = s_reg.cctl;
        end else if (SFR_ADDR == ADDR_CC0) begin
            s_next.rdata = s_reg.cc0;
        end else if (SFR_ADDR == ADDR_CC1) begin
            s_next.rdata = s_reg.cc1;
        end else begin
            s_next.rdata = 8'h00;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s_reg <= ST_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign SFR_RDATA = s_reg.rdata;
    assign CH0_OUT = s_reg.out;
    // pin is driven only in compare mode
    assign CH0_OE_N = ~s_reg.cctl[CCTL_MODE];
    assign OVF_FLAG = s_reg.ovf_p;
    assign OVF_IRQ = s_reg.ovf_irq;
    assign CH0_FLAG = s_reg.ch0_p;
    assign CH0_IRQ = s_reg.ch0_irq;
    assign DMA_CH0 = s_reg.dma0_p;
    assign DMA_CH1 = s_reg.dma1_p;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_clr_zeroes: assert property (clr_w |=> s_reg.cnt == CNT_ZERO)
        else $error("clear did not zero counter");
    a_clr_reads: assert property (SFR_ADDR == ADDR_CTL |=> !SFR_RDATA[CTL_CLR])
        else $error("clear bit read as one");
    a_halt_hold: assert property (!started && !SFR_WR |=> $stable(s_reg.cnt))
        else $error("halted counter moved");
    a_free_wrap: assert property (top_ev && mode == MODE_FREE && !SFR_WR
        |=> s_reg.cnt == CNT_ZERO && OVF_FLAG)
        else $error("free run wrap wrong");
    a_mod_wrap: assert property (match0 && mode == MODE_MOD && !SFR_WR
        |=> s_reg.cnt == CNT_ZERO && OVF_FLAG)
        else $error("modulo wrap wrong");
    a_down_step: assert property (tick_hit && mode == MODE_DOWN && s_reg.cnt != CNT_ZERO && !SFR_WR
        |=> s_reg.cnt == $past(s_reg.cnt) - 8'h01)
        else $error("down count step wrong");
    a_ud_turn: assert property (up_m && mode == MODE_UPDN && s_reg.cnt != CNT_ZERO && !SFR_WR
        |=> s_reg.down && s_reg.cnt == $past(s_reg.cnt) - 8'h01)
        else $error("up/down did not turn");
    a_dma0_pulse: assert property (cmp_en && match0 |=> DMA_CH0 && CH0_FLAG)
        else $error("channel 0 trigger missing");
    a_dma0_cause: assert property (!match0 |=> !DMA_CH0)
        else $error("spurious channel 0 trigger");
    a_dma1_pulse: assert property (tick_hit && s_reg.cnt == s_reg.cc1 |=> DMA_CH1)
        else $error("channel 1 trigger missing");
    a_cap_copy: assert property (cap_hit |=> s_reg.cc0 == $past(s_reg.cnt) && CH0_FLAG)
        else $error("capture did not copy count");
    a_cmp_defer: assert property (s_reg.cnt != CNT_ZERO |=> $stable(s_reg.cc0_act))
        else $error("compare value changed early");
    a_set_out: assert property (cmp_en && act == ACT_SET && match0 |=> CH0_OUT)
        else $error("set action failed");
    a_ovf_irq: assert property (OVF_IRQ |-> OVF_FLAG)
        else $error("overflow request without flag");

    c_capture: cover property (cap_hit);
    c_dma0: cover property (DMA_CH0);
    c_ud_ovf: cover property (OVF_FLAG && mode == MODE_UPDN);
    c_clear: cover property (clr_w && started);
endmodule : tm8_timer

// ==== tb/tm8_event_sink.sv ====
// Purpose: far-side stand-in for the flag register and dma controller
// Assumes: every event output is a one-cycle pulse on clk
// Notes: a pulse held two cycles counts twice, as a real trigger would
`timescale 1ns/1ps
module tm8_event_sink (
    input wire logic clk,
    input wire logic clr,
    input wire logic [5:0] pulse,
    output logic [5:0][7:0] hits
);
    always_ff @(posedge clk) begin
        for (int i = 0; i < 6; i++) begin
            hits[i] <= clr ? 8'h00 : hits[i] + {7'h00, pulse[i]};
        end
    end
endmodule : tm8_event_sink

// ==== tb/tb_tm8_timer.sv ====
// Purpose: register-level bench for the 8-bit timer
// Assumes: inputs change 1 ns after the rising edge
// Notes: a run leaves the counter at edges = gap + 1
`timescale 1ns/1ps
`define CHK(g, e) check_val(8'(g), 8'(e))
module tb_tm8_timer;
    import tm8_pkg::*;
    logic CLK, RST, TICK, SFR_WR, CH0_IN, CH0_OUT, CH0_OE_N;
    logic OVF_FLAG, OVF_IRQ, CH0_FLAG, CH0_IRQ, DMA_CH0, DMA_CH1, sink_clr;
    logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, got;
    logic [5:0][7:0] hits;
    logic [7:0] cmp_tab [8] = '{8'h44, 8'h4C, 8'h54, 8'h54, 8'h5C, 8'h64, 8'h6C, 8'h34};
    int n_mismatch = 0;
    int num_checks = 0;
    tm8_timer u_dut (.CLK(CLK), .RST(RST), .TICK(TICK), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
        .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .CH0_IN(CH0_IN), .CH0_OUT(CH0_OUT),
        .CH0_OE_N(CH0_OE_N), .OVF_FLAG(OVF_FLAG), .OVF_IRQ(OVF_IRQ), .CH0_FLAG(CH0_FLAG),
        .CH0_IRQ(CH0_IRQ), .DMA_CH0(DMA_CH0), .DMA_CH1(DMA_CH1));
    tm8_event_sink u_sink (.clk(CLK), .clr(sink_clr),
        .pulse({DMA_CH1, DMA_CH0, CH0_IRQ, CH0_FLAG, OVF_IRQ, OVF_FLAG}), .hits(hits));
    task automatic check_val(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check_val
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WR = 1'b1;
        @(posedge CLK);
        #1;
    endtask : wr
    // strobe stays up after wr; the next rd or cyc drops it, so no double assignment
    task automatic rd(input logic [7:0] a);
        SFR_WR = 1'b0;
        SFR_ADDR = a;
        @(posedge CLK);
        #1 got = SFR_RDATA;
    endtask : rd
    task automatic cyc(input int n);
        SFR_WR = 1'b0;
        repeat (n) @(posedge CLK);
        #1;
    endtask : cyc
    // start, wait, stop: the stop edge still counts
    task automatic run(input logic [7:0] on, input int k, input logic [7:0] off);
        wr(ADDR_CTL, on);
        cyc(k);
        wr(ADDR_CTL, off);
    endtask : run
    task automatic zero_hits();
        sink_clr = 1'b1;
        cyc(1);
        sink_clr = 1'b0;
    endtask : zero_hits
    task automatic end_test(input string name);
        $display("test %s done, %0d mismatches so far", name, n_mismatch);
    endtask : end_test
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // whole run is about 1840 cycles
    initial begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        $display("watchdog ran out at %0t", $time);
        give_verdict();
    end
    initial begin
        {RST, sink_clr, TICK} = 3'b111;
        {SFR_WR, CH0_IN, SFR_ADDR, SFR_WDATA} = '0;
        repeat (20) @(posedge CLK);
        #1 {RST, sink_clr} = 2'b00;
        rd(ADDR_CNT); `CHK(got, 8'h00);
        rd(ADDR_CTL); `CHK(got, 8'h08);
        rd(ADDR_CCTL0); `CHK(got, 8'h40);
        rd(ADDR_CC0); `CHK(got, 8'h00);
        wr(ADDR_CNT, 8'h55);
        wr(8'hCE, 8'h77);
        wr(ADDR_CC0, 8'hA5);
        wr(ADDR_CCTL0, 8'hFF);
        rd(ADDR_CNT); `CHK(got, 8'h00);
        rd(8'hCE); `CHK(got, 8'h00);
        rd(ADDR_CC0); `CHK(got, 8'hA5);
        rd(ADDR_CCTL0); `CHK(got, 8'h7F);
        `CHK(CH0_OE_N, 0);
        wr(ADDR_CCTL0, 8'h41);
        `CHK(CH0_OE_N, 1);
        end_test("registers");
        for (int d = 0; d < 8; d++) begin
            run({3'(d), 5'b11100}, 127, {3'(d), 5'b01000});
            rd(ADDR_CNT); `CHK(got, 128 >> d);
        end
        cyc(20);
        rd(ADDR_CNT); `CHK(got, 8'h01);
        wr(ADDR_CTL, 8'h0C);
        rd(ADDR_CTL); `CHK(got, 8'h08);
        rd(ADDR_CNT); `CHK(got, 8'h00);
        end_test("prescaler");
        zero_hits();
        run(8'h1C, 256, 8'h08);
        rd(ADDR_CNT); `CHK(got, 8'h01);
        `CHK(hits[0], 1);
        run(8'h14, 256, 8'h00);
        `CHK(hits[0], 2);
        `CHK(hits[1], 1);
        end_test("overflow");
        zero_hits();
        wr(ADDR_CC0, 8'h09);
        run(8'h1E, 24, 8'h0A);
        rd(ADDR_CNT); `CHK(got, 8'h05);
        wr(ADDR_CTL, 8'h0D);
        run(8'h19, 3, 8'h09);
        rd(ADDR_CNT); `CHK(got, 8'h05);
        run(8'h19, 10, 8'h09);
        rd(ADDR_CNT); `CHK(got, 8'h00);
        wr(ADDR_CC0, 8'h03);
        wr(ADDR_CTL, 8'h0F);
        run(8'h1B, 3, 8'h0B);
        rd(ADDR_CNT); `CHK(got, 8'h02);
        run(8'h1B, 1, 8'h0B);
        rd(ADDR_CNT); `CHK(got, 8'h00);
        `CHK(hits[0], 3);
        end_test("modes");
        wr(ADDR_CC1, 8'h07);
        wr(ADDR_CC0, 8'h05);
        wr(ADDR_CTL, 8'h0C);
        zero_hits();
        // set, clear, toggle twice, then the paired actions; last row masked
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_CCTL0, cmp_tab[i]);
            run(8'h1C, 9, 8'h08);
            `CHK(CH0_OUT, i % 2 == 0);
        end
        `CHK(hits[4], 8);
        `CHK(hits[5], 8);
        `CHK(hits[2], 8);
        `CHK(hits[3], 7);
        end_test("compare");
        // slowest prescale keeps the count at zero through every capture
        wr(ADDR_CTL, 8'hFC);
        zero_hits();
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_CCTL0, 8'(8'h40 | c));
            wr(ADDR_CC0, 8'hAA);
            CH0_IN = 1'b1;
            cyc(6);
            CH0_IN = 1'b0;
            cyc(6);
            rd(ADDR_CC0); `CHK(got, (c == 0) ? 8'hAA : 8'h00);
        end
        `CHK(hits[2], 4);
        end_test("capture");
        give_verdict();
    end
endmodule : tb_tm8_timer
